// ===== shared/sesl_pkg.sv
// Constants and types for the standard event status logic
package sesl_pkg;
    // Standard event register bit positions
    localparam int SESL_EV_OPC = 0;
    localparam int SESL_EV_UNUSED1 = 1;
    localparam int SESL_EV_QUERY = 2;
    localparam int SESL_EV_DEVICE = 3;
    localparam int SESL_EV_EXEC = 4;
    localparam int SESL_EV_CMD = 5;
    localparam int SESL_EV_UNUSED6 = 6;
    localparam int SESL_EV_PON = 7;
    // Status byte bit positions
    localparam int SESL_SB_ERRQ = 2;
    localparam int SESL_SB_QUES = 3;
    localparam int SESL_SB_MAV = 4;
    localparam int SESL_SB_ESB = 5;
    localparam int SESL_SB_MSS = 6;
    // Bits that can ever hold a one in the event register
    localparam logic [7:0] SESL_EV_USED = 8'hBD;
    // Status byte bits other than MSS that can ever hold a one
    localparam logic [7:0] SESL_SB_USED = 8'h3C;
    // Reset values
    localparam logic [7:0] SESL_FLAGS_RST = 8'h80;
    localparam logic [7:0] SESL_MASK_RST = 8'h00;
    localparam logic [7:0] SESL_ZERO8 = 8'h00;

    // Common commands issued by the parser
    typedef enum logic [2:0] {
        SESL_CMD_NONE,
        SESL_CMD_CLS,
        SESL_CMD_ESE_WR,
        SESL_CMD_ESE_RD,
        SESL_CMD_ESR_RD,
        SESL_CMD_SRE_WR,
        SESL_CMD_SRE_RD,
        SESL_CMD_STB_RD
    } sesl_cmd_e;

    // Request from the command parser
    typedef struct packed {
        logic valid;
        sesl_cmd_e cmd;
        logic [7:0] value;
    } sesl_req_s;

    // Event pulses from the rest of the instrument
    typedef struct packed {
        logic opc_armed;
        logic ops_done;
        logic errq_empty_read;
        logic stale_read;
        logic buffer_full;
        logic device_fault;
        logic exec_fail;
        logic syntax_err;
    } sesl_evt_s;
endpackage

// ===== src/sesl_status.sv
// Standard event register, enable masks and status byte summary
`timescale 1ns/10ps
module sesl_status
    import sesl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire sesl_req_s req,
    input wire sesl_evt_s evt,
    input wire logic out_queue_avail,
    input wire logic out_buffer_full,
    input wire logic error_queue_nonempty,
    input wire logic questionable_summary,
    output logic resp_valid,
    output logic [7:0] resp_value,
    output logic [7:0] standard_event_flags,
    output logic [7:0] event_enable_mask,
    output logic [7:0] service_request_mask,
    output logic [7:0] status_byte,
    output logic acquire_halt
);
    logic [7:0] raw_events;
    logic [7:0] next_flags;
    logic [7:0] next_status;
    logic cmd_go;
    logic opc_pending;
    logic [7:0] next_event_mask;
    logic [7:0] next_service_mask;

    assign cmd_go = clk_en && req.valid;

    // Masks land at the same edge as the status byte, so the summary bits
    // never judge events against a stale mask for one cycle
    always_comb begin
        next_event_mask = event_enable_mask;
        if (cmd_go && req.cmd == SESL_CMD_ESE_WR) begin
            next_event_mask = req.value;
        end
    end

    always_comb begin
        next_service_mask = service_request_mask;
        if (cmd_go && req.cmd == SESL_CMD_SRE_WR) begin
            next_service_mask = req.value;
        end
    end

    // Completion request waits for pending operations
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            opc_pending <= 1'b0;
        end else if (clk_en) begin
            if (evt.opc_armed && !evt.ops_done) begin
                opc_pending <= 1'b1;
            end else if (evt.ops_done) begin
                opc_pending <= 1'b0;
            end
        end
    end

    always_comb begin
        raw_events = SESL_ZERO8;
        raw_events[SESL_EV_OPC] = (opc_pending || evt.opc_armed) && evt.ops_done;
        raw_events[SESL_EV_QUERY] = evt.errq_empty_read || evt.stale_read
            || evt.buffer_full;
        raw_events[SESL_EV_DEVICE] = evt.device_fault;
        raw_events[SESL_EV_EXEC] = evt.exec_fail;
        raw_events[SESL_EV_CMD] = evt.syntax_err;
    end

    // Clear on query or clear-status, new events win over the clear
    always_comb begin
        next_flags = standard_event_flags;
        if (cmd_go && (req.cmd == SESL_CMD_CLS || req.cmd == SESL_CMD_ESR_RD)) begin
            next_flags = SESL_ZERO8;
        end
        next_flags = (next_flags | (raw_events & event_enable_mask))
            & SESL_EV_USED;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            standard_event_flags <= SESL_FLAGS_RST;
        end else if (clk_en) begin
            standard_event_flags <= next_flags;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            event_enable_mask <= SESL_MASK_RST;
        end else if (clk_en) begin
            event_enable_mask <= next_event_mask;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            service_request_mask <= SESL_MASK_RST;
        end else if (clk_en) begin
            service_request_mask <= next_service_mask;
        end
    end

    always_comb begin
        next_status = SESL_ZERO8;
        next_status[SESL_SB_ERRQ] = error_queue_nonempty;
        next_status[SESL_SB_QUES] = questionable_summary;
        next_status[SESL_SB_MAV] = out_queue_avail;
        next_status[SESL_SB_ESB] = |(next_flags & next_event_mask);
        next_status[SESL_SB_MSS] = |(next_status & next_service_mask
            & SESL_SB_USED);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_byte <= SESL_ZERO8;
        end else if (clk_en) begin
            status_byte <= next_status;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acquire_halt <= 1'b0;
        end else if (clk_en) begin
            acquire_halt <= out_buffer_full;
        end
    end

    // Query answers, one cycle after the request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_value <= SESL_ZERO8;
        end else if (clk_en) begin
            resp_valid <= 1'b0;
            if (req.valid) begin
                case (req.cmd)
                    SESL_CMD_ESE_RD: begin
                        resp_valid <= 1'b1;
                        resp_value <= event_enable_mask;
                    end
                    SESL_CMD_ESR_RD: begin
                        resp_valid <= 1'b1;
                        resp_value <= standard_event_flags;
                    end
                    SESL_CMD_SRE_RD: begin
                        resp_valid <= 1'b1;
                        resp_value <= service_request_mask;
                    end
                    SESL_CMD_STB_RD: begin
                        resp_valid <= 1'b1;
                        resp_value <= status_byte;
                    end
                    default: begin
                        resp_valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Event register
    a_unused_zero: assert property (@(posedge ref_clk) disable iff (rst)
        standard_event_flags[SESL_EV_UNUSED1] == 1'b0
        && standard_event_flags[SESL_EV_UNUSED6] == 1'b0)
        else $error("Unused event bit set");
    a_esr_clears: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && req.valid && req.cmd == SESL_CMD_ESR_RD && raw_events == 8'h00)
        |=> standard_event_flags == 8'h00)
        else $error("Event query did not clear");
    a_cls_clears: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_go && req.cmd == SESL_CMD_CLS && raw_events == 8'h00)
        |=> standard_event_flags == 8'h00)
        else $error("Clear-status did not clear");
    a_esr_answer: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && req.valid && req.cmd == SESL_CMD_ESR_RD)
        |=> resp_valid && resp_value == $past(standard_event_flags))
        else $error("Event query answer wrong");
    a_latch_holds: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && !(req.valid && (req.cmd == SESL_CMD_CLS
        || req.cmd == SESL_CMD_ESR_RD)))
        |=> (standard_event_flags & $past(standard_event_flags))
        == $past(standard_event_flags))
        else $error("Event bit lost");
    a_gated_set: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en |=> (standard_event_flags & ~$past(standard_event_flags)
        & ~$past(event_enable_mask)) == 8'h00)
        else $error("Masked event latched");
    a_opc_same: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && evt.opc_armed && evt.ops_done && event_enable_mask[SESL_EV_OPC])
        |=> standard_event_flags[SESL_EV_OPC])
        else $error("Operation complete missed");
    a_opc_later: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && opc_pending && evt.ops_done && event_enable_mask[SESL_EV_OPC])
        |=> standard_event_flags[SESL_EV_OPC])
        else $error("Delayed operation complete missed");
    a_query_err: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && (evt.errq_empty_read || evt.stale_read || evt.buffer_full)
        && event_enable_mask[SESL_EV_QUERY])
        |=> standard_event_flags[SESL_EV_QUERY])
        else $error("Query error missed");
    a_device_err: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && evt.device_fault && event_enable_mask[SESL_EV_DEVICE])
        |=> standard_event_flags[SESL_EV_DEVICE])
        else $error("Device error missed");
    a_exec_err: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && evt.exec_fail && event_enable_mask[SESL_EV_EXEC])
        |=> standard_event_flags[SESL_EV_EXEC])
        else $error("Execution error missed");
    a_cmd_err: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && evt.syntax_err && event_enable_mask[SESL_EV_CMD])
        |=> standard_event_flags[SESL_EV_CMD])
        else $error("Command error missed");

    // Masks, status byte and halt
    a_ese_write: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_go && req.cmd == SESL_CMD_ESE_WR)
        |=> event_enable_mask == $past(req.value))
        else $error("Enable mask not written");
    a_sre_write: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_go && req.cmd == SESL_CMD_SRE_WR)
        |=> service_request_mask == $past(req.value))
        else $error("Service mask not written");
    a_ese_query: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && req.valid && req.cmd == SESL_CMD_ESE_RD)
        |=> resp_valid && resp_value == $past(event_enable_mask)
        && event_enable_mask == $past(event_enable_mask))
        else $error("Enable mask query wrong");
    a_sre_query: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && req.valid && req.cmd == SESL_CMD_SRE_RD)
        |=> resp_valid && resp_value == $past(service_request_mask)
        && service_request_mask == $past(service_request_mask))
        else $error("Service mask query wrong");
    a_esb_summary: assert property (@(posedge ref_clk) disable iff (rst)
        status_byte[SESL_SB_ESB] == |(standard_event_flags & event_enable_mask))
        else $error("Event summary wrong");
    a_mss_summary: assert property (@(posedge ref_clk) disable iff (rst)
        status_byte[SESL_SB_MSS] == |(status_byte & service_request_mask
        & SESL_SB_USED))
        else $error("Master summary wrong");
    a_stb_answer: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && req.valid && req.cmd == SESL_CMD_STB_RD)
        |=> resp_valid && resp_value == $past(status_byte))
        else $error("Status query answer wrong");
    a_stb_keeps: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_go && req.cmd == SESL_CMD_STB_RD && status_byte[SESL_SB_MSS]
        && status_byte[SESL_SB_ESB] && service_request_mask[SESL_SB_ESB])
        |=> status_byte[SESL_SB_MSS])
        else $error("Status query cleared summary");
    a_sb_unused: assert property (@(posedge ref_clk) disable iff (rst)
        (status_byte & ~(SESL_SB_USED | (8'h01 << SESL_SB_MSS))) == 8'h00)
        else $error("Unused status bit set");
    a_mav_follow: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en |=> status_byte[SESL_SB_MAV] == $past(out_queue_avail))
        else $error("Message available wrong");
    a_halt_follow: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en |=> acquire_halt == $past(out_buffer_full))
        else $error("Acquisition halt wrong");

    // Nothing moves while the clock enable is low, and writes give no answer
    a_state_frozen: assert property (@(posedge ref_clk) disable iff (rst)
        !clk_en |=> $stable(standard_event_flags) && $stable(event_enable_mask)
        && $stable(service_request_mask) && $stable(status_byte)
        && $stable(acquire_halt))
        else $error("State moved while frozen");
    a_write_silent: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && req.valid && (req.cmd == SESL_CMD_CLS
        || req.cmd == SESL_CMD_ESE_WR || req.cmd == SESL_CMD_SRE_WR))
        |=> !resp_valid)
        else $error("Write gave an answer");

    c_opc_set: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(standard_event_flags[SESL_EV_OPC]));
    c_esb_set: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(status_byte[SESL_SB_ESB]));
    c_mss_set: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(status_byte[SESL_SB_MSS]));
    c_esr_clear: cover property (@(posedge ref_clk) disable iff (rst)
        cmd_go && req.cmd == SESL_CMD_ESR_RD && standard_event_flags != 8'h00);
    c_stb_mss: cover property (@(posedge ref_clk) disable iff (rst)
        cmd_go && req.cmd == SESL_CMD_STB_RD && status_byte[SESL_SB_MSS]);
endmodule // sesl_status

// ===== tb/sesl_ctrl_model.sv
// Remote controller model that issues common commands
`timescale 1ns/10ps
module sesl_ctrl_model
    import sesl_pkg::*;
(
    input wire logic ref_clk,
    output sesl_req_s req
);
    initial req = '0;
    // One request, then the value lines are left toggled and idle time follows
    task automatic issue(input sesl_cmd_e cmd, input logic [7:0] value);
        @(posedge ref_clk);
        req <= '{valid: 1'b1, cmd: cmd, value: value};
        @(posedge ref_clk);
        req.valid <= 1'b0;
        req.value <= ~value;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule // sesl_ctrl_model

// ===== tb/sesl_status_tb.sv
// Self-checking testbench for the standard event status logic
`timescale 1ns/10ps
module sesl_status_tb;
    import sesl_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    sesl_evt_s evt = '0;
    logic mav = 1'b0, full = 1'b0, errq = 1'b0, ques = 1'b0;
    sesl_req_s req;
    logic resp_valid, acquire_halt;
    logic [7:0] resp_value, flags, ese, sre, sb, r;
    logic [7:0] exp_q[$];
    logic [7:0] tab[6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h04};
    int n_mismatch = 0, n_checks = 0;
    always #25 ref_clk = ~ref_clk;
    sesl_ctrl_model i_sesl_ctrl_model(.ref_clk(ref_clk), .req(req));
    sesl_status i_sesl_status(.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .req(req),
        .evt(evt), .out_queue_avail(mav), .out_buffer_full(full),
        .error_queue_nonempty(errq), .questionable_summary(ques), .resp_valid(resp_valid),
        .resp_value(resp_value), .standard_event_flags(flags), .event_enable_mask(ese),
        .service_request_mask(sre), .status_byte(sb), .acquire_halt(acquire_halt));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Each answer is matched against the oldest expectation
    always @(negedge ref_clk) begin
        if (resp_valid === 1'b1) begin
            cmp(resp_value, exp_q.size() > 0 ? exp_q.pop_front() : ~resp_value);
        end
    end
    task automatic q(input sesl_cmd_e c, input logic [7:0] e);
        exp_q.push_back(e);
        i_sesl_ctrl_model.issue(c, 8'h00);
    endtask
    task automatic w(input sesl_cmd_e c, input logic [7:0] v);
        i_sesl_ctrl_model.issue(c, v);
    endtask
    // Pulse events, then let the summary bits settle
    task automatic ev(input logic [7:0] b);
        @(posedge ref_clk);
        evt <= sesl_evt_s'(b);
        @(posedge ref_clk);
        evt <= '0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h8FB74C6F));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        cmp(flags, SESL_FLAGS_RST);
        q(SESL_CMD_ESR_RD, 8'h80);
        q(SESL_CMD_ESR_RD, 8'h00);
        done("power_on");
        r = 8'($urandom);
        w(SESL_CMD_ESE_WR, r);
        cmp(ese, r);
        q(SESL_CMD_ESE_RD, r);
        clk_en <= 1'b0;
        w(SESL_CMD_ESE_WR, ~r);
        clk_en <= 1'b1;
        q(SESL_CMD_ESE_RD, r);
        r = 8'($urandom);
        w(SESL_CMD_SRE_WR, r);
        q(SESL_CMD_SRE_RD, r);
        cmp(sre, r);
        done("masks");
        w(SESL_CMD_ESE_WR, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            ev(8'h01 << i);
            q(SESL_CMD_ESR_RD, tab[i]);
        end
        ev(8'h40);
        q(SESL_CMD_ESR_RD, 8'h00);
        ev(8'hC0);
        q(SESL_CMD_ESR_RD, 8'h01);
        ev(8'h80);
        ev(8'h40);
        q(SESL_CMD_ESR_RD, 8'h01);
        ev(8'hFF);
        q(SESL_CMD_ESR_RD, 8'h3D);
        w(SESL_CMD_ESE_WR, 8'hDF);
        ev(8'h01);
        q(SESL_CMD_ESR_RD, 8'h00);
        done("events");
        w(SESL_CMD_ESE_WR, 8'h20);
        w(SESL_CMD_SRE_WR, 8'h20);
        {errq, ques, mav} <= 3'b111;
        ev(8'h01);
        q(SESL_CMD_STB_RD, 8'h7C);
        q(SESL_CMD_STB_RD, 8'h7C);
        w(SESL_CMD_CLS, 8'h00);
        cmp(sb, 8'h1C);
        q(SESL_CMD_STB_RD, 8'h1C);
        r = 8'($urandom);
        w(SESL_CMD_SRE_WR, r);
        mav <= 1'b0;
        repeat (3) @(posedge ref_clk);
        q(SESL_CMD_STB_RD, {1'b0, |r[3:2], 6'h0C});
        @(posedge ref_clk) full <= 1'b1;
        repeat (2) @(negedge ref_clk);
        cmp({7'h00, acquire_halt}, 8'h01);
        @(posedge ref_clk) full <= 1'b0;
        repeat (2) @(negedge ref_clk);
        cmp({7'h00, acquire_halt}, 8'h00);
        done("status_byte");
        for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge ref_clk);
        if (exp_q.size() > 0) n_mismatch++;
        stop_test();
    end
endmodule // sesl_status_tb
